// File: design/tolo_pkg.sv
// constants, register map and types shared by the thermal overload output logic
package tolo_pkg;
	// clock and program cycle timing
	localparam int CLK_PERIOD_NS     = 100;
	localparam int PROG_CYCLE_US     = 5000;
	localparam int PROG_CYCLE_CYCLES = (PROG_CYCLE_US * 1000) / CLK_PERIOD_NS;
	localparam int TRIP_STEP_US      = 5000;

	// register byte offsets
	localparam logic [7:0] ADDR_CTRL      = 8'h00;
	localparam logic [7:0] ADDR_ALARM1    = 8'h04;
	localparam logic [7:0] ADDR_ALARM2    = 8'h08;
	localparam logic [7:0] ADDR_INHIBIT   = 8'h0c;
	localparam logic [7:0] ADDR_TRIP      = 8'h10;
	localparam logic [7:0] ADDR_DELAY     = 8'h14;
	localparam logic [7:0] ADDR_PICKUP    = 8'h18;
	localparam logic [7:0] ADDR_STATUS    = 8'h1c;
	localparam logic [7:0] ADDR_BLOCK_EVT = 8'h20;

	// control register fields
	localparam int CTRL_ALARM1_EN  = 0;
	localparam int CTRL_ALARM2_EN  = 1;
	localparam int CTRL_INHIBIT_EN = 2;
	localparam int CTRL_FUNC_ON    = 3;
	localparam int CTRL_TEST_MODE  = 4;
	localparam int CTRL_FORCE_EN   = 5;
	localparam int CTRL_FORCE_BLK  = 6;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0008;

	// thresholds in 0.1 % of thermal capacity
	localparam int          THR_W           = 11;
	localparam logic [10:0] THR_MAX         = 11'h5dc;
	localparam logic [10:0] ALARM1_RESET    = 11'h190;
	localparam logic [10:0] ALARM2_RESET    = 11'h190;
	localparam logic [10:0] INHIBIT_RESET   = 11'h320;
	localparam logic [10:0] TRIP_RESET      = 11'h3e8;

	// trip delay in 5 ms steps, 3600.000 s at most
	localparam int          DELAY_W         = 20;
	localparam logic [19:0] DELAY_MAX       = 20'ha_fc80;
	localparam logic [19:0] DELAY_RESET     = 20'h0_0000;

	// currents in 0.1 % of nominal current
	localparam logic [15:0] LIGHT_LOAD_LIM  = 16'h000a;
	localparam logic [15:0] HIGH_LOAD_LIM   = 16'h07d0;
	localparam logic [15:0] PICKUP_RESET    = 16'h03e8;

	// setting factors in hundredths, substitute value 1.00
	localparam logic [15:0] FACTOR_ONE      = 16'h0064;

	// status register fields
	localparam int STAT_COND_LSB  = 8;
	localparam int STAT_LN_LSB    = 12;
	localparam int STAT_LOAD_LSB  = 16;
	localparam int STAT_FAULT_LSB = 20;

	typedef enum logic [1:0] {TS_IDLE, TS_START, TS_TRIP, TS_BLOCKED} tolo_trip_state_type;

	typedef enum logic [2:0] {
		COND_NORMAL  = 3'h0,
		COND_ALARM1  = 3'h1,
		COND_ALARM2  = 3'h2,
		COND_INHIBIT = 3'h3,
		COND_TRIP    = 3'h4,
		COND_BLOCKED = 3'h5
	} tolo_cond_type;

	typedef enum logic [2:0] {
		LN_ON       = 3'h1,
		LN_BLOCKED  = 3'h2,
		LN_TEST     = 3'h3,
		LN_TEST_BLK = 3'h4,
		LN_OFF      = 3'h5
	} tolo_ln_type;

	typedef enum logic [1:0] {LOAD_LIGHT, LOAD_NORMAL, LOAD_OVER, LOAD_HIGH} tolo_load_type;
endpackage

// File: design/tolo_sync.sv
// three-stage synchroniser with agreement filter for a pin input
`timescale 1ns/10ps
module tolo_sync import tolo_pkg::*; (
	input  wire logic clk,
	input  wire logic nrst,
	input  wire logic din,
	output logic      dout
);
	logic s1_reg;
	logic s2_reg;
	logic s3_reg;

	// a change is taken only once stages two and three agree
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			s1_reg <= 1'b0;
			s2_reg <= 1'b0;
			s3_reg <= 1'b0;
			dout   <= 1'b0;
		end else begin
			s1_reg <= din;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			if (s2_reg == s3_reg) begin
				dout <= s3_reg;
			end
		end
	end
endmodule

// File: design/tolo_tick.sv
// program cycle divider producing a one-cycle enable pulse
`timescale 1ns/10ps
module tolo_tick import tolo_pkg::*; #(
	parameter int CYCLES = PROG_CYCLE_CYCLES
) (
	input  wire logic clk,
	input  wire logic nrst,
	output logic      tick
);
	logic [31:0] cnt_reg;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			cnt_reg <= 32'h0000_0000;
			tick    <= 1'b0;
		end else if (cnt_reg == 32'(CYCLES - 1)) begin
			cnt_reg <= 32'h0000_0000;
			tick    <= 1'b1;
		end else begin
			cnt_reg <= cnt_reg + 32'h0000_0001;
			tick    <= 1'b0;
		end
	end
endmodule

// File: design/tolo_top.sv
// thermal overload output, trip blocking and status logic with wishbone registers
`timescale 1ns/10ps
module tolo_top import tolo_pkg::*; #(
	parameter int PROG_CYCLES = PROG_CYCLE_CYCLES
) (
	input  wire logic        CLK,
	input  wire logic        NRST,
	input  wire logic        WB_CYC_I,
	input  wire logic        WB_STB_I,
	input  wire logic        WB_WE_I,
	input  wire logic [7:0]  WB_ADR_I,
	input  wire logic [3:0]  WB_SEL_I,
	input  wire logic [31:0] WB_DAT_I,
	output logic [31:0]      WB_DAT_O,
	output logic             WB_ACK_O,
	input  wire logic [10:0] THERMAL_CAP,
	input  wire logic [15:0] LOAD_CURRENT,
	input  wire logic        BLOCK_PIN,
	input  wire logic [15:0] SERVICE_FACTOR,
	input  wire logic        SERVICE_FACTOR_BAD,
	input  wire logic [15:0] AMBIENT_K,
	input  wire logic        AMBIENT_BAD,
	input  wire logic [15:0] NOMINAL_SCALE,
	input  wire logic        NOMINAL_BAD,
	input  wire logic        AMBIENT_K_INCONSISTENT,
	output logic             FIRST_ALARM,
	output logic             SECOND_ALARM,
	output logic             RESTART_INHIBIT,
	output logic             TRIP,
	output logic             START,
	output logic             BLOCKED,
	output logic [2:0]       OPERATING_CONDITION,
	output logic [2:0]       LOGICAL_NODE_MODE,
	output logic [1:0]       LOAD_CLASS,
	output logic [3:0]       SETTING_FAULT_FLAG,
	output logic [15:0]      USED_SERVICE_FACTOR,
	output logic [15:0]      USED_AMBIENT_K,
	output logic [15:0]      USED_NOMINAL_SCALE,
	output logic             DISPLAY_EVENT,
	output logic             BLOCK_EVENT,
	output logic [15:0]      BLOCK_EVT_CURRENT,
	output logic [2:0]       BLOCK_EVT_FAULT
);
	////////////////////////////////////////////////////////////////////////////////
	// register bus

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
		input logic [3:0] sel);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++) begin
			if (sel[i]) begin
				res[8*i +: 8] = wd[8*i +: 8];
			end
		end
		return res;
	endfunction

	function automatic logic [10:0] clamp_thr(input logic [31:0] v);
		return (v > 32'(THR_MAX)) ? THR_MAX : v[10:0];
	endfunction

	logic [31:0]         ctrl_reg;
	logic [10:0]         alarm1_thr_reg;
	logic [10:0]         alarm2_thr_reg;
	logic [10:0]         inhibit_thr_reg;
	logic [10:0]         trip_thr_reg;
	logic [19:0]         delay_reg;
	logic [15:0]         pickup_reg;
	logic [31:0]         rdata_next;
	logic [31:0]         status_word;
	logic                tick;
	logic                pin_blk;
	logic                blk_reg;
	logic [19:0]         cnt_reg;
	tolo_trip_state_type state_reg;
	tolo_trip_state_type state_next;

	wire req     = WB_CYC_I & WB_STB_I;
	// writes land at the edge where the master samples the ack
	wire wr_en   = req & WB_WE_I & WB_ACK_O;
	wire wr_ctrl = wr_en & (WB_ADR_I == ADDR_CTRL);
	wire wr_a1   = wr_en & (WB_ADR_I == ADDR_ALARM1);
	wire wr_a2   = wr_en & (WB_ADR_I == ADDR_ALARM2);
	wire wr_inh  = wr_en & (WB_ADR_I == ADDR_INHIBIT);
	wire wr_trip = wr_en & (WB_ADR_I == ADDR_TRIP);
	wire wr_dly  = wr_en & (WB_ADR_I == ADDR_DELAY);
	wire wr_pick = wr_en & (WB_ADR_I == ADDR_PICKUP);

	wire [31:0] wd_a1   = merge(32'(alarm1_thr_reg), WB_DAT_I, WB_SEL_I);
	wire [31:0] wd_a2   = merge(32'(alarm2_thr_reg), WB_DAT_I, WB_SEL_I);
	wire [31:0] wd_inh  = merge(32'(inhibit_thr_reg), WB_DAT_I, WB_SEL_I);
	wire [31:0] wd_trip = merge(32'(trip_thr_reg), WB_DAT_I, WB_SEL_I);
	wire [31:0] wd_dly  = merge(32'(delay_reg), WB_DAT_I, WB_SEL_I);
	wire [31:0] wd_pick = merge(32'(pickup_reg), WB_DAT_I, WB_SEL_I);

	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			ctrl_reg        <= CTRL_RESET;
			alarm1_thr_reg  <= ALARM1_RESET;
			alarm2_thr_reg  <= ALARM2_RESET;
			inhibit_thr_reg <= INHIBIT_RESET;
			trip_thr_reg    <= TRIP_RESET;
			delay_reg       <= DELAY_RESET;
			pickup_reg      <= PICKUP_RESET;
		end else begin
			if (wr_ctrl) begin
				ctrl_reg <= merge(ctrl_reg, WB_DAT_I, WB_SEL_I) & 32'h0000_007f;
			end
			// out-of-range thresholds and delay saturate rather than wrap; the pick-up keeps its low 16 bits
			if (wr_a1) begin
				alarm1_thr_reg <= clamp_thr(wd_a1);
			end
			if (wr_a2) begin
				alarm2_thr_reg <= clamp_thr(wd_a2);
			end
			if (wr_inh) begin
				inhibit_thr_reg <= clamp_thr(wd_inh);
			end
			if (wr_trip) begin
				trip_thr_reg <= clamp_thr(wd_trip);
			end
			if (wr_dly) begin
				delay_reg <= (wd_dly > 32'(DELAY_MAX)) ? DELAY_MAX : wd_dly[19:0];
			end
			if (wr_pick) begin
				pickup_reg <= wd_pick[15:0];
			end
		end
	end

	always_comb begin
		if (WB_ADR_I == ADDR_CTRL) begin
			rdata_next = ctrl_reg;
		end else if (WB_ADR_I == ADDR_ALARM1) begin
			rdata_next = 32'(alarm1_thr_reg);
		end else if (WB_ADR_I == ADDR_ALARM2) begin
			rdata_next = 32'(alarm2_thr_reg);
		end else if (WB_ADR_I == ADDR_INHIBIT) begin
			rdata_next = 32'(inhibit_thr_reg);
		end else if (WB_ADR_I == ADDR_TRIP) begin
			rdata_next = 32'(trip_thr_reg);
		end else if (WB_ADR_I == ADDR_DELAY) begin
			rdata_next = 32'(delay_reg);
		end else if (WB_ADR_I == ADDR_PICKUP) begin
			rdata_next = 32'(pickup_reg);
		end else if (WB_ADR_I == ADDR_STATUS) begin
			rdata_next = status_word;
		end else if (WB_ADR_I == ADDR_BLOCK_EVT) begin
			rdata_next = {13'h0000, BLOCK_EVT_FAULT, BLOCK_EVT_CURRENT};
		end else begin
			rdata_next = 32'h0000_0000;
		end
	end

	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			WB_ACK_O <= 1'b0;
			WB_DAT_O <= 32'h0000_0000;
		end else begin
			WB_ACK_O <= req & ~WB_ACK_O;
			if (req & ~WB_ACK_O) begin
				WB_DAT_O <= rdata_next;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// blocking source and program cycle

	tolo_tick #(.CYCLES(PROG_CYCLES)) u_tick (
		.clk  (CLK),
		.nrst (NRST),
		.tick (tick)
	);

	tolo_sync u_blk_sync (
		.clk  (CLK),
		.nrst (NRST),
		.din  (BLOCK_PIN),
		.dout (pin_blk)
	);

	wire func_on   = ctrl_reg[CTRL_FUNC_ON];
	wire force_on  = ctrl_reg[CTRL_FORCE_EN];
	// software switch takes over the blocking input only under stage forcing
	wire blk_src   = force_on ? ctrl_reg[CTRL_FORCE_BLK] : pin_blk;

	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			blk_reg <= 1'b0;
		end else if (tick) begin
			blk_reg <= blk_src;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// level comparisons, trip path

	wire cap_a1   = THERMAL_CAP >= alarm1_thr_reg;
	wire cap_a2   = THERMAL_CAP >= alarm2_thr_reg;
	wire cap_inh  = THERMAL_CAP >= inhibit_thr_reg;
	wire pickup   = func_on & (THERMAL_CAP >= trip_thr_reg);
	wire a1_next  = func_on & ctrl_reg[CTRL_ALARM1_EN] & cap_a1;
	wire a2_next  = func_on & ctrl_reg[CTRL_ALARM2_EN] & cap_a2;
	wire inh_next = func_on & ctrl_reg[CTRL_INHIBIT_EN] & cap_inh;
	wire delay_done = cnt_reg >= delay_reg;

	always_comb begin
		state_next = state_reg;
		case (state_reg)
			TS_IDLE: begin
				if (tick & pickup & blk_src) begin
					state_next = TS_BLOCKED;
				end else if (tick & pickup) begin
					state_next = (delay_reg == DELAY_RESET) ? TS_TRIP : TS_START;
				end
			end
			TS_START: begin
				if (!pickup) begin
					state_next = TS_IDLE;
				end else if (tick & blk_src) begin
					state_next = TS_IDLE;
				end else if (tick & delay_done) begin
					state_next = TS_TRIP;
				end
			end
			TS_TRIP: begin
				if (!pickup || (tick & blk_src)) begin
					state_next = TS_IDLE;
				end
			end
			TS_BLOCKED: begin
				if (!pickup || (tick & ~blk_src)) begin
					state_next = TS_IDLE;
				end
			end
			default: begin
				state_next = TS_IDLE;
			end
		endcase
	end

	wire blk_evt = tick & blk_src & pickup & (state_reg != TS_BLOCKED);

	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			state_reg <= TS_IDLE;
			cnt_reg   <= DELAY_RESET;
		end else begin
			state_reg <= state_next;
			// counting one step per program cycle keeps the 5 ms resolution
			if (state_next != TS_START) begin
				cnt_reg <= DELAY_RESET;
			end else if (tick) begin
				cnt_reg <= cnt_reg + 20'h0_0001;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// status codes and setting faults

	wire blk_now = state_next == TS_BLOCKED;
	wire trip_now = state_next == TS_TRIP;
	wire [2:0] cond_next = blk_now ? COND_BLOCKED : trip_now ? COND_TRIP
		: inh_next ? COND_INHIBIT : a2_next ? COND_ALARM2 : a1_next ? COND_ALARM1
		: COND_NORMAL;
	wire test_on = ctrl_reg[CTRL_TEST_MODE];
	wire [2:0] ln_next = !func_on ? LN_OFF : (test_on & blk_reg) ? LN_TEST_BLK
		: test_on ? LN_TEST : blk_reg ? LN_BLOCKED : LN_ON;
	wire [1:0] load_next = (LOAD_CURRENT < LIGHT_LOAD_LIM) ? LOAD_LIGHT
		: (LOAD_CURRENT > HIGH_LOAD_LIM) ? LOAD_HIGH
		: (LOAD_CURRENT > pickup_reg) ? LOAD_OVER : LOAD_NORMAL;

	assign status_word = {8'h00, SETTING_FAULT_FLAG, 2'b00, LOAD_CLASS, 1'b0,
		LOGICAL_NODE_MODE, 1'b0, OPERATING_CONDITION, 2'b00, BLOCKED, START, TRIP,
		RESTART_INHIBIT, SECOND_ALARM, FIRST_ALARM};

	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			FIRST_ALARM         <= 1'b0;
			SECOND_ALARM        <= 1'b0;
			RESTART_INHIBIT     <= 1'b0;
			TRIP                <= 1'b0;
			START               <= 1'b0;
			BLOCKED             <= 1'b0;
			OPERATING_CONDITION <= COND_NORMAL;
			LOGICAL_NODE_MODE   <= LN_ON;
			LOAD_CLASS          <= LOAD_LIGHT;
			SETTING_FAULT_FLAG  <= 4'h0;
			USED_SERVICE_FACTOR <= FACTOR_ONE;
			USED_AMBIENT_K      <= FACTOR_ONE;
			USED_NOMINAL_SCALE  <= FACTOR_ONE;
			DISPLAY_EVENT       <= 1'b0;
			BLOCK_EVENT         <= 1'b0;
			BLOCK_EVT_CURRENT   <= 16'h0000;
			BLOCK_EVT_FAULT     <= 3'h0;
		end else begin
			FIRST_ALARM         <= a1_next;
			SECOND_ALARM        <= a2_next;
			RESTART_INHIBIT     <= inh_next;
			TRIP                <= trip_now;
			START               <= (state_next == TS_START) | trip_now;
			BLOCKED             <= blk_now;
			OPERATING_CONDITION <= cond_next;
			LOGICAL_NODE_MODE   <= ln_next;
			LOAD_CLASS          <= load_next;
			// flags follow the fault inputs, so they show only while a fault exists
			SETTING_FAULT_FLAG  <= {AMBIENT_K_INCONSISTENT, NOMINAL_BAD, AMBIENT_BAD,
				SERVICE_FACTOR_BAD};
			USED_SERVICE_FACTOR <= SERVICE_FACTOR_BAD ? FACTOR_ONE : SERVICE_FACTOR;
			USED_AMBIENT_K      <= AMBIENT_BAD ? FACTOR_ONE : AMBIENT_K;
			USED_NOMINAL_SCALE  <= NOMINAL_BAD ? FACTOR_ONE : NOMINAL_SCALE;
			DISPLAY_EVENT       <= blk_evt;
			BLOCK_EVENT         <= blk_evt;
			if (blk_evt) begin
				BLOCK_EVT_CURRENT <= LOAD_CURRENT;
				BLOCK_EVT_FAULT   <= cond_next;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// assertions and covers

	default clocking cb @(posedge CLK); endclocking
	default disable iff (!NRST);

	alarm1_gate_a: assert property (!ctrl_reg[CTRL_ALARM1_EN] |=> !FIRST_ALARM)
		else $error("first alarm active while disabled");
	alarm1_level_a: assert property ((func_on && ctrl_reg[CTRL_ALARM1_EN]
		&& THERMAL_CAP >= alarm1_thr_reg) |=> FIRST_ALARM)
		else $error("first alarm missed at threshold");
	alarm2_gate_a: assert property (!ctrl_reg[CTRL_ALARM2_EN] |=> !SECOND_ALARM)
		else $error("second alarm active while disabled");
	inhibit_gate_a: assert property (!(func_on && ctrl_reg[CTRL_INHIBIT_EN])
		|=> !RESTART_INHIBIT)
		else $error("inhibit active while disabled");
	block_sample_a: assert property (!tick |=> $stable(blk_reg))
		else $error("blocking sampled outside program cycle start");
	start_entry_a: assert property ((tick && state_reg == TS_IDLE
		&& pickup && !blk_src && delay_reg != DELAY_RESET) |=> START && !TRIP)
		else $error("start not raised on unblocked pick-up");
	blocked_entry_a: assert property ((tick && state_reg == TS_IDLE
		&& pickup && blk_src) |=> BLOCKED && !START && !TRIP)
		else $error("blocked pick-up not stopped");
	block_release_a: assert property ((tick && state_reg == TS_START && blk_src)
		|=> !START ##1 !START)
		else $error("start survived blocking");
	block_event_a: assert property (blk_evt |=> BLOCK_EVENT && DISPLAY_EVENT
		&& BLOCK_EVT_CURRENT == $past(LOAD_CURRENT))
		else $error("blocking event missing");
	trip_delay_a: assert property ((state_reg == TS_START && cnt_reg < delay_reg)
		|=> !TRIP)
		else $error("trip before extra delay");
	normal_quiet_a: assert property (OPERATING_CONDITION == COND_NORMAL
		|-> !(FIRST_ALARM | SECOND_ALARM | RESTART_INHIBIT | TRIP))
		else $error("output driven in normal condition");
	sf_override_a: assert property (SERVICE_FACTOR_BAD
		|=> USED_SERVICE_FACTOR == FACTOR_ONE && SETTING_FAULT_FLAG[0])
		else $error("service factor not overridden");

	trip_seen_c: cover property (START ##[1:8] TRIP);
	blocked_seen_c: cover property (BLOCK_EVENT ##1 BLOCKED);
	release_seen_c: cover property (START ##1 !START && !TRIP);
endmodule

// File: tb/tolo_blk_src.sv
// blocking matrix source model that drives the blocking pin
`timescale 1ns/10ps
module tolo_blk_src (
	input  wire logic clk,
	input  wire logic nrst,
	input  wire logic want,
	output logic      pin
);
	// the bench raises want a full program cycle before any delay ends
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst)
			pin <= 1'b0;
		else
			pin <= want;
	end
endmodule

// File: tb/testbench.sv
// self-checking bench for the thermal overload output logic
`timescale 1ns/10ps
module testbench import tolo_pkg::*; ;
	localparam int P = 20;
	logic        CLK = 1'b0, NRST = 1'b0, WB_CYC_I = 1'b0, WB_STB_I = 1'b0, WB_WE_I = 1'b0;
	logic        SERVICE_FACTOR_BAD = 1'b0, AMBIENT_BAD = 1'b0, NOMINAL_BAD = 1'b0;
	logic        AMBIENT_K_INCONSISTENT = 1'b0, block_want = 1'b0, BLOCK_PIN;
	logic [7:0]  WB_ADR_I = 8'h00;
	logic [3:0]  WB_SEL_I = 4'h0, SETTING_FAULT_FLAG;
	logic [31:0] WB_DAT_I = 32'h0000_0000, WB_DAT_O, rd;
	logic [10:0] THERMAL_CAP = 11'h000;
	logic [15:0] LOAD_CURRENT = 16'h0000, SERVICE_FACTOR = 16'h00fa, AMBIENT_K = 16'h0050;
	logic [15:0] NOMINAL_SCALE = 16'h0078, USED_SERVICE_FACTOR, USED_AMBIENT_K;
	logic [15:0] USED_NOMINAL_SCALE, BLOCK_EVT_CURRENT;
	logic        WB_ACK_O, FIRST_ALARM, SECOND_ALARM, RESTART_INHIBIT, TRIP, START, BLOCKED;
	logic        DISPLAY_EVENT, BLOCK_EVENT;
	logic [2:0]  OPERATING_CONDITION, LOGICAL_NODE_MODE, BLOCK_EVT_FAULT;
	logic [1:0]  LOAD_CLASS;
	wire  [5:0]  lvl = {FIRST_ALARM, SECOND_ALARM, RESTART_INHIBIT, OPERATING_CONDITION};
	int          num_errors = 0, checks = 0, evt_cnt = 0;
	logic [10:0] caps [4] = '{11'h1f3, 11'h1f4, 11'h258, 11'h2bc};
	logic [5:0]  outs [4] = '{6'h00, 6'h21, 6'h32, 6'h3b};
	logic [7:0]  ctrls [5] = '{8'h07, 8'h1f, 8'h7f, 8'h6f, 8'h0f};
	logic [2:0]  modes [5] = '{LN_OFF, LN_TEST, LN_TEST_BLK, LN_BLOCKED, LN_ON};
	logic [15:0] loads [4] = '{16'h0009, 16'h000a, 16'h07d0, 16'h07d1};

	always #50 CLK = ~CLK;

	// event pulses last one cycle, so they are counted rather than polled
	always @(negedge CLK) begin
		if (BLOCK_EVENT === 1'b1 && DISPLAY_EVENT === 1'b1)
			evt_cnt <= evt_cnt + 1;
	end

	tolo_top #(.PROG_CYCLES(P)) uut (.CLK, .NRST, .WB_CYC_I, .WB_STB_I, .WB_WE_I, .WB_ADR_I,
		.WB_SEL_I, .WB_DAT_I, .WB_DAT_O, .WB_ACK_O, .THERMAL_CAP, .LOAD_CURRENT, .BLOCK_PIN,
		.SERVICE_FACTOR, .SERVICE_FACTOR_BAD, .AMBIENT_K, .AMBIENT_BAD, .NOMINAL_SCALE,
		.NOMINAL_BAD, .AMBIENT_K_INCONSISTENT, .FIRST_ALARM, .SECOND_ALARM, .RESTART_INHIBIT,
		.TRIP, .START, .BLOCKED, .OPERATING_CONDITION, .LOGICAL_NODE_MODE, .LOAD_CLASS,
		.SETTING_FAULT_FLAG, .USED_SERVICE_FACTOR, .USED_AMBIENT_K, .USED_NOMINAL_SCALE,
		.DISPLAY_EVENT, .BLOCK_EVENT, .BLOCK_EVT_CURRENT, .BLOCK_EVT_FAULT);
	tolo_blk_src blk (.clk(CLK), .nrst(NRST), .want(block_want), .pin(BLOCK_PIN));

	////////////////////////////////////////////////////////////////////////////////
	task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("FAIL %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task tally_and_finish;
		$display("checks %0d mismatches %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task cyc(input int n);
		repeat (n) @(negedge CLK);
	endtask

	task set_cap(input logic [10:0] v);
		@(posedge CLK);
		THERMAL_CAP <= v;
	endtask

	// classic single cycle; read data is taken at the edge that samples the ack
	task wb(input logic we, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge CLK);
		WB_CYC_I <= 1'b1;
		WB_STB_I <= 1'b1;
		WB_WE_I <= we;
		WB_ADR_I <= a;
		WB_SEL_I <= 4'hf;
		WB_DAT_I <= d;
		@(negedge CLK);
		while (WB_ACK_O !== 1'b1) begin
			n++;
			if (n > 20) begin
				check("bus ack", 32'(WB_ACK_O), 32'h0000_0001);
				tally_and_finish;
			end
			@(negedge CLK);
		end
		@(posedge CLK);
		rd = WB_DAT_O;
		WB_CYC_I <= 1'b0;
		WB_STB_I <= 1'b0;
		@(posedge CLK);
	endtask

	task wait_start;
		int n;
		n = 0;
		while (START !== 1'b1 && n < 3 * P) begin
			@(negedge CLK);
			n++;
		end
		check("start", 32'(START), 32'h0000_0001);
		if (START !== 1'b1)
			tally_and_finish;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	task t_defaults;
		wb(0, ADDR_CTRL, 0);
		check("ctrl", rd, CTRL_RESET);
		wb(0, ADDR_ALARM1, 0);
		check("a1 thr", rd, 32'(ALARM1_RESET));
		wb(0, ADDR_ALARM2, 0);
		check("a2 thr", rd, 32'(ALARM2_RESET));
		wb(0, ADDR_INHIBIT, 0);
		check("inh thr", rd, 32'(INHIBIT_RESET));
		wb(0, ADDR_TRIP, 0);
		check("trip thr", rd, 32'(TRIP_RESET));
		wb(0, ADDR_DELAY, 0);
		check("delay", rd, 32'(DELAY_RESET));
		wb(0, 8'h40, 0);
		check("unmapped", rd, 32'h0000_0000);
		wb(1, ADDR_ALARM1, 32'h0000_0fff);
		wb(0, ADDR_ALARM1, 0);
		check("a1 sat", rd, 32'(THR_MAX));
		set_cap(11'h5dc);
		cyc(2);
		check("disabled", 32'(lvl[5:3]), 0);
		set_cap(11'h000);
		$display("test defaults done");
	endtask

	task t_levels;
		wb(1, ADDR_TRIP, 32'h0000_05dc);
		wb(1, ADDR_ALARM1, 32'h0000_01f4);
		wb(1, ADDR_ALARM2, 32'h0000_0258);
		wb(1, ADDR_INHIBIT, 32'h0000_02bc);
		wb(1, ADDR_CTRL, 32'h0000_000f);
		for (int i = 0; i < 4; i++) begin
			set_cap(caps[i]);
			cyc(2);
			check("levels", 32'(lvl), 32'(outs[i]));
		end
		for (int i = 0; i < 5; i++) begin
			wb(1, ADDR_CTRL, 32'(ctrls[i]));
			cyc(P + 4);
			check("ln mode", 32'(LOGICAL_NODE_MODE), 32'(modes[i]));
			if (i == 0)
				check("off outs", 32'(lvl), 0);
		end
		wb(1, ADDR_CTRL, 32'h0000_0008);
		wb(1, ADDR_TRIP, 32'h0000_03e8);
		set_cap(11'h000);
		$display("test levels done");
	endtask

	task t_trip;
		wb(1, ADDR_DELAY, 32'h0000_0002);
		set_cap(11'h3e8);
		wait_start;
		cyc(2 * P - 1);
		check("trip early", 32'(TRIP), 0);
		cyc(1);
		check("trip late", 32'({TRIP, OPERATING_CONDITION}), 32'h0000_000c);
		set_cap(11'h000);
		cyc(2);
		check("drop", 32'({START, TRIP}), 0);
		wb(1, ADDR_DELAY, 32'h0000_0000);
		set_cap(11'h3e8);
		wait_start;
		check("trip now", 32'(TRIP), 32'h0000_0001);
		set_cap(11'h000);
		$display("test trip done");
	endtask

	task t_block;
		wb(1, ADDR_DELAY, 32'h0000_0005);
		@(posedge CLK);
		LOAD_CURRENT <= 16'h04d2;
		set_cap(11'h3e8);
		wait_start;
		@(posedge CLK);
		block_want <= 1'b1;
		cyc(P + 6);
		check("start cleared", 32'({START, TRIP}), 0);
		cyc(P);
		check("blocked", 32'({BLOCKED, OPERATING_CONDITION}), 32'h0000_000d);
		check("ln blocked", 32'(LOGICAL_NODE_MODE), 32'(LN_BLOCKED));
		check("evt seen", 32'(evt_cnt != 0), 32'h0000_0001);
		wb(0, ADDR_BLOCK_EVT, 0);
		check("evt data", rd, 32'h0005_04d2);
		wb(0, ADDR_STATUS, 0);
		check("status", rd, 32'h0002_2520);
		@(posedge CLK);
		block_want <= 1'b0;
		set_cap(11'h000);
		cyc(P + 8);
		check("unblocked", 32'({BLOCKED, LOGICAL_NODE_MODE}), 32'(LN_ON));
		$display("test block done");
	endtask

	task t_faults;
		for (int i = 0; i < 4; i++) begin
			@(posedge CLK);
			{AMBIENT_K_INCONSISTENT, NOMINAL_BAD, AMBIENT_BAD, SERVICE_FACTOR_BAD} <= 4'(1 << i);
			LOAD_CURRENT <= loads[i];
			cyc(2);
			check("fault flag", 32'(SETTING_FAULT_FLAG), 32'(1 << i));
			check("sf", 32'(USED_SERVICE_FACTOR), 32'(i == 0 ? FACTOR_ONE : SERVICE_FACTOR));
			check("amb", 32'(USED_AMBIENT_K), 32'(i == 1 ? FACTOR_ONE : AMBIENT_K));
			check("nom", 32'(USED_NOMINAL_SCALE), 32'(i == 2 ? FACTOR_ONE : NOMINAL_SCALE));
			check("load", 32'(LOAD_CLASS), 32'(i));
		end
		$display("test faults done");
	endtask

	initial begin
		repeat (5) @(posedge CLK);
		NRST <= 1'b1;
		t_defaults;
		t_levels;
		t_trip;
		t_block;
		t_faults;
		tally_and_finish;
	end
endmodule
